/* hdl/deriv_regs_pkg.sv */
// Constants for the derivative register bank: offsets, fields, options.
// Assumes an 8-bit address space on a single 100 MHz core clock.
package deriv_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] EEPROM_BYTE_POINTER_ADR       = 8'h01;
  localparam logic [7:0] EEPROM_DATA_PORT_ADR          = 8'h03;
  localparam logic [7:0] EEPROM_CYCLE_CONTROL_ADR      = 8'h04;
  localparam logic [7:0] TIMER_TWO_RELOAD_ADR          = 8'h05;
  localparam logic [7:0] TIMER_TWO_COUNT_ADR           = 8'h06;
  localparam logic [7:0] FACTORY_TEST_ADR              = 8'h07;
  localparam logic [7:0] HIGH_TONE_FREQUENCY_ADR       = 8'h11;
  localparam logic [7:0] LOW_TONE_FREQUENCY_ADR        = 8'h12;
  localparam logic [7:0] TONE_CLOCK_MELODY_CONTROL_ADR = 8'h13;
  localparam logic [7:0] AUX_PORT_A_PINS_ADR           = 8'h30;
  localparam logic [7:0] AUX_PORT_B_PINS_ADR           = 8'h31;
  localparam logic [7:0] AUX_PORT_A_LATCH_ADR          = 8'h32;
  localparam logic [7:0] AUX_PORT_B_LATCH_ADR          = 8'h33;

  // ---------------------------------------------------------------
  // Field layouts and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] POINTER_MASK   = 8'h7F;
  localparam logic [7:0] CONTROL_MASK   = 8'hFE;
  localparam logic [7:0] TONE_CTRL_MASK = 8'h07;
  localparam int GENERAL_TIMER_RUN_BIT  = 7;
  localparam int TIMER_IRQ_ENABLE_BIT   = 6;
  localparam int TIMER_EXPIRED_FLAG_BIT = 5;
  localparam int NVM_CYCLE_GO_BIT       = 4;
  localparam logic [7:0] CYCLE_BITS_MASK = 8'h1E;
  localparam int TONE_CLOCK_OUT_ENABLE_BIT  = 2;
  localparam int DIVIDE_BY_THREE_SELECT_BIT = 1;
  localparam int MELODY_OUT_ENABLE_BIT      = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Mask options and tone clock divider
  // ---------------------------------------------------------------
  localparam logic [1:0] OPT_STANDARD   = 2'h1;
  localparam logic [1:0] OPT_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] OPT_PUSH_PULL  = 2'h3;
  localparam logic [1:0] DIV_HALF_TWO   = 2'h1;
  localparam logic [1:0] DIV_HALF_THREE = 2'h2;
  localparam int TONE_CLOCK_LINE = 15;

endpackage : deriv_regs_pkg

/* hdl/derivative_register_map_ports.sv */
// Derivative register bank with two 8-line auxiliary ports and the
// melody and tone clock pin drivers.
// Assumes the core on mclk_in drives a plain strobe register port;
// pin inputs are asynchronous; EEPROM and timer logic sit outside.
//
// Overview of operation
// - Port A pin levels read back at 30h, read only.
// - Port B pin levels read back at 31h, read only.
// - Melody pin push-pull for options 1 and 3, open-drain for 2.
// - Tone clock pin push-pull for options 1 and 3, open-drain for 2.
// - Byte pointer at 01h holds 7 bits; bit 7 reads zero.
// - EEPROM data register at 03h, 8 bits read and write.
// - Cycle control at 04h: run, irq enable, flag, go, op code; bit 0 zero.
// - Timer two reload at 05h, 8 bits read and write.
// - High tone frequency at 11h is write only.
// - Low tone frequency at 12h is write only.
// - Control at 13h: tone clock enable, divide by three, melody enable.
// - Port A latch at 32h, 8 bits read and write.
// - Port B latch at 33h, 8 bits read and write.
// - Reset clears every derivative register.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps

module derivative_register_map_ports #(
  parameter logic [1:0] port_a_option   = deriv_regs_pkg::OPT_STANDARD,
  parameter logic [1:0] port_b_option   = deriv_regs_pkg::OPT_STANDARD,
  parameter logic [1:0] melody_option   = deriv_regs_pkg::OPT_STANDARD,
  parameter logic [1:0] tone_clk_option = deriv_regs_pkg::OPT_STANDARD
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // EEPROM and timer two side
  input  wire logic [7:0]  timer_two_count_in,
  input  wire logic        timer_expired_set_in,
  input  wire logic        nvm_cycle_done_in,
  output logic      [7:0]  eeprom_byte_pointer_out,
  output logic      [7:0]  eeprom_data_port_out,
  output logic      [7:0]  eeprom_cycle_control_out,
  output logic      [7:0]  timer_two_reload_out,
  output logic             eeprom_data_wr_out,
  output logic             eeprom_data_rd_out,
  // Tone generator side
  output logic      [7:0]  high_tone_frequency_out,
  output logic      [7:0]  low_tone_frequency_out,
  output logic      [2:0]  tone_clock_melody_control_out,
  input  wire logic        melody_src_in,
  // Melody pin
  output logic             melody_pin_out,
  output logic             melody_pin_oe_out,
  // Auxiliary port pins, A in bits 7:0, B in bits 15:8
  input  wire logic [15:0] aux_pins_in,
  output logic      [15:0] aux_pins_out,
  output logic      [15:0] aux_pins_oe_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] pins_meta_reg;
  logic [15:0] pins_sync_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pins_meta_reg <= 16'h0000;
      pins_sync_reg <= 16'h0000;
    end
    else
    begin
      pins_meta_reg <= aux_pins_in;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  logic [7:0] ctrl_next;
  logic [7:0] ctrl_written;

  always_comb
  begin
    ctrl_written = wdata_in & deriv_regs_pkg::CONTROL_MASK;
    ctrl_next    = eeprom_cycle_control_out;
    if (wr_in && addr_in == deriv_regs_pkg::EEPROM_CYCLE_CONTROL_ADR)
      ctrl_next = ctrl_written;
    // End of an EEPROM cycle drops go and op code
    if (nvm_cycle_done_in)
      ctrl_next = ctrl_next & ~deriv_regs_pkg::CYCLE_BITS_MASK;
    // Hardware set beats a software clear in the same cycle
    if (timer_expired_set_in)
      ctrl_next[deriv_regs_pkg::TIMER_EXPIRED_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      eeprom_cycle_control_out <= deriv_regs_pkg::REG_RESET;
    else
      eeprom_cycle_control_out <= ctrl_next;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      eeprom_byte_pointer_out       <= deriv_regs_pkg::REG_RESET;
      eeprom_data_port_out          <= deriv_regs_pkg::REG_RESET;
      timer_two_reload_out          <= deriv_regs_pkg::REG_RESET;
      high_tone_frequency_out       <= deriv_regs_pkg::REG_RESET;
      low_tone_frequency_out        <= deriv_regs_pkg::REG_RESET;
      tone_clock_melody_control_out <= 3'h0;
    end
    else if (wr_in)
    begin
      // Unlisted offsets, 07h included, fall through untouched
      case (addr_in)
        deriv_regs_pkg::EEPROM_BYTE_POINTER_ADR:
          eeprom_byte_pointer_out <= wdata_in & deriv_regs_pkg::POINTER_MASK;
        deriv_regs_pkg::EEPROM_DATA_PORT_ADR:
          eeprom_data_port_out <= wdata_in;
        deriv_regs_pkg::TIMER_TWO_RELOAD_ADR:
          timer_two_reload_out <= wdata_in;
        deriv_regs_pkg::HIGH_TONE_FREQUENCY_ADR:
          high_tone_frequency_out <= wdata_in;
        deriv_regs_pkg::LOW_TONE_FREQUENCY_ADR:
          low_tone_frequency_out <= wdata_in;
        deriv_regs_pkg::TONE_CLOCK_MELODY_CONTROL_ADR:
          tone_clock_melody_control_out <= wdata_in[2:0];
        default:
          tone_clock_melody_control_out <= tone_clock_melody_control_out;
      endcase
    end
  end

  // Port latches, kept apart: they feed the pin drivers directly
  logic [15:0] aux_latch_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      aux_latch_reg <= 16'h0000;
    else if (wr_in && addr_in == deriv_regs_pkg::AUX_PORT_A_LATCH_ADR)
      aux_latch_reg[7:0] <= wdata_in;
    else if (wr_in && addr_in == deriv_regs_pkg::AUX_PORT_B_LATCH_ADR)
      aux_latch_reg[15:8] <= wdata_in;
  end

  // Data strobes let the EEPROM side load or fetch a byte
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      eeprom_data_wr_out <= 1'b0;
      eeprom_data_rd_out <= 1'b0;
    end
    else
    begin
      eeprom_data_wr_out <= wr_in && addr_in == deriv_regs_pkg::EEPROM_DATA_PORT_ADR;
      eeprom_data_rd_out <= rd_in && addr_in == deriv_regs_pkg::EEPROM_DATA_PORT_ADR;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        deriv_regs_pkg::EEPROM_BYTE_POINTER_ADR:
          rdata_next = eeprom_byte_pointer_out & deriv_regs_pkg::POINTER_MASK;
        deriv_regs_pkg::EEPROM_DATA_PORT_ADR:
          rdata_next = eeprom_data_port_out;
        deriv_regs_pkg::EEPROM_CYCLE_CONTROL_ADR:
          rdata_next = eeprom_cycle_control_out & deriv_regs_pkg::CONTROL_MASK;
        deriv_regs_pkg::TIMER_TWO_RELOAD_ADR:
          rdata_next = timer_two_reload_out;
        deriv_regs_pkg::TIMER_TWO_COUNT_ADR:
          rdata_next = timer_two_count_in;
        deriv_regs_pkg::TONE_CLOCK_MELODY_CONTROL_ADR:
          rdata_next = {5'h00, tone_clock_melody_control_out};
        deriv_regs_pkg::AUX_PORT_A_PINS_ADR:
          rdata_next = pins_sync_reg[7:0];
        deriv_regs_pkg::AUX_PORT_B_PINS_ADR:
          rdata_next = pins_sync_reg[15:8];
        deriv_regs_pkg::AUX_PORT_A_LATCH_ADR:
          rdata_next = aux_latch_reg[7:0];
        deriv_regs_pkg::AUX_PORT_B_LATCH_ADR:
          rdata_next = aux_latch_reg[15:8];
        // Write-only tone registers and test address read zero
        default:
          rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else
      rdata_out <= rdata_next;
  end

  // ---------------------------------------------------------------
  // Tone clock divider
  // ---------------------------------------------------------------
  // Half period of two or three cycles; restarts while disabled
  logic [1:0] div_cnt_reg;
  logic       tone_clk_reg;
  logic [1:0] div_limit;
  logic       tone_clk_on;

  assign tone_clk_on = tone_clock_melody_control_out[deriv_regs_pkg::TONE_CLOCK_OUT_ENABLE_BIT];
  assign div_limit = tone_clock_melody_control_out[deriv_regs_pkg::DIVIDE_BY_THREE_SELECT_BIT]
                   ? deriv_regs_pkg::DIV_HALF_THREE : deriv_regs_pkg::DIV_HALF_TWO;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt_reg  <= 2'h0;
      tone_clk_reg <= 1'b0;
    end
    else if (!tone_clk_on)
    begin
      div_cnt_reg  <= 2'h0;
      tone_clk_reg <= 1'b0;
    end
    else if (div_cnt_reg >= div_limit)
    begin
      div_cnt_reg  <= 2'h0;
      tone_clk_reg <= ~tone_clk_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 2'h1;
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Standard port lines other than the tone clock line pull low only; the weak pull-up is outside
  logic [15:0] pin_val;
  logic [15:0] pin_oe;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_line
      localparam logic [1:0] OPT = (gi < 8) ? port_a_option : port_b_option;
      if (gi == deriv_regs_pkg::TONE_CLOCK_LINE)
      begin : g_dco
        logic v;
        assign v = tone_clk_on ? tone_clk_reg : aux_latch_reg[gi];
        assign pin_val[gi] = (tone_clk_option == deriv_regs_pkg::OPT_OPEN_DRAIN)
                           ? 1'b0 : v;
        assign pin_oe[gi]  = (tone_clk_option == deriv_regs_pkg::OPT_OPEN_DRAIN)
                           ? ~v : 1'b1;
      end
      else
      begin : g_plain
        assign pin_val[gi] = (OPT == deriv_regs_pkg::OPT_PUSH_PULL)
                           ? aux_latch_reg[gi] : 1'b0;
        assign pin_oe[gi]  = (OPT == deriv_regs_pkg::OPT_PUSH_PULL)
                           ? 1'b1 : ~aux_latch_reg[gi];
      end
    end
  endgenerate

  logic mdy_v;
  logic mdy_od;

  assign mdy_v  = tone_clock_melody_control_out[deriv_regs_pkg::MELODY_OUT_ENABLE_BIT]
                ? melody_src_in : 1'b1;
  assign mdy_od = (melody_option == deriv_regs_pkg::OPT_OPEN_DRAIN);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aux_pins_out      <= 16'h0000;
      aux_pins_oe_out   <= 16'h0000;
      melody_pin_out    <= 1'b0;
      melody_pin_oe_out <= 1'b0;
    end
    else
    begin
      aux_pins_out      <= pin_val;
      aux_pins_oe_out   <= pin_oe;
      melody_pin_out    <= mdy_od ? 1'b0 : mdy_v;
      melody_pin_oe_out <= mdy_od ? ~mdy_v : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd(logic [7:0] a);
    rd_in && addr_in == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    wr_in && addr_in == a;
  endsequence

  a_port_a_read: assert property (s_rd(deriv_regs_pkg::AUX_PORT_A_PINS_ADR)
      |=> rdata_out == $past(pins_sync_reg[7:0]))
    else $error("port A pin read wrong");
  a_port_b_read: assert property (s_rd(deriv_regs_pkg::AUX_PORT_B_PINS_ADR)
      |=> rdata_out == $past(pins_sync_reg[15:8]))
    else $error("port B pin read wrong");
  // Output flops still show reset values one edge past release
  a_melody_drive: assert property (!mdy_od && $past(rst_n_in) |-> melody_pin_oe_out)
    else $error("melody drive wrong");
  a_melody_od_low: assert property (mdy_od |-> !melody_pin_out)
    else $error("melody open-drain drives high");
  a_dco_push_pull: assert property (
      tone_clk_option != deriv_regs_pkg::OPT_OPEN_DRAIN && $past(rst_n_in)
      |-> aux_pins_oe_out[deriv_regs_pkg::TONE_CLOCK_LINE])
    else $error("tone clock pin not driven");
  a_pointer_bit7: assert property (
      s_wr(deriv_regs_pkg::EEPROM_BYTE_POINTER_ADR)
      ##1 s_rd(deriv_regs_pkg::EEPROM_BYTE_POINTER_ADR)
      |=> rdata_out == {1'b0, $past(wdata_in[6:0], 2)})
    else $error("pointer readback wrong");
  a_data_round: assert property (
      s_wr(deriv_regs_pkg::EEPROM_DATA_PORT_ADR)
      ##1 s_rd(deriv_regs_pkg::EEPROM_DATA_PORT_ADR)
      |=> rdata_out == $past(wdata_in, 2))
    else $error("data readback wrong");
  a_control_bit0: assert property (s_rd(deriv_regs_pkg::EEPROM_CYCLE_CONTROL_ADR)
      |=> !rdata_out[0])
    else $error("control bit 0 set");
  a_flag_set_wins: assert property (timer_expired_set_in
      |=> eeprom_cycle_control_out[deriv_regs_pkg::TIMER_EXPIRED_FLAG_BIT])
    else $error("expired flag lost");
  a_reload_store: assert property (s_wr(deriv_regs_pkg::TIMER_TWO_RELOAD_ADR)
      |=> timer_two_reload_out == $past(wdata_in))
    else $error("reload not stored");
  a_tone_wo_read: assert property (s_rd(deriv_regs_pkg::HIGH_TONE_FREQUENCY_ADR)
      or s_rd(deriv_regs_pkg::LOW_TONE_FREQUENCY_ADR) |=> rdata_out == 8'h00)
    else $error("write-only register read back");
  a_tone_ctrl_hi: assert property (s_rd(deriv_regs_pkg::TONE_CLOCK_MELODY_CONTROL_ADR)
      |=> rdata_out[7:3] == 5'h00)
    else $error("control upper bits set");
  // Standard and open-drain lines drive only where the latch bit is clear
  a_latch_a_pin: assert property (s_wr(deriv_regs_pkg::AUX_PORT_A_LATCH_ADR)
      |=> ##1 aux_pins_oe_out[7:0] == ((port_a_option == deriv_regs_pkg::OPT_PUSH_PULL)
              ? 8'hFF : ~$past(wdata_in, 2)))
    else $error("port A latch not on pins");
  a_latch_b_read: assert property (
      s_wr(deriv_regs_pkg::AUX_PORT_B_LATCH_ADR)
      ##1 s_rd(deriv_regs_pkg::AUX_PORT_B_LATCH_ADR)
      |=> rdata_out == $past(wdata_in, 2))
    else $error("port B latch readback wrong");
  a_unused_zero: assert property (s_rd(8'h00) or s_rd(deriv_regs_pkg::FACTORY_TEST_ADR)
      or s_rd(8'h40) |=> rdata_out == 8'h00)
    else $error("unused address read nonzero");

endmodule : derivative_register_map_ports

/* test/derivative_register_map_ports_tb_top.sv */
// Self-checking bench for the derivative register bank and its pin drivers.
// Assumes the design package is compiled first; drives all ports directly.
`timescale 1ns/100ps

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end

module derivative_register_map_ports_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_s;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [7:0]  rdata_out;
  logic [7:0]  tcount = 8'h00;
  logic        tset = 1'b0;
  logic        ndone = 1'b0;
  logic        melody_src_in = 1'b0;
  logic [15:0] aux_pins_in = 16'h0000;
  logic [7:0]  ptr_o, dat_o, ctl_o, rel_o, hi_o, lo_o;
  logic [2:0]  tcm_o;
  logic        dwr_o, drd_o, mel_o, mel_oe, od_mel_o, od_mel_oe;
  logic [15:0] pins_o, pins_oe, od_pins_o, od_pins_oe;
  logic [7:0]  rv;
  int          err_count = 0;
  int          n_checks = 0;
  int          tp, tod;
  // Rows never touch the factory test address
  row_s        rows [14] = '{'{8'h01, 8'hFF, 8'h7F}, '{8'h03, 8'hA5, 8'hA5},
    '{8'h04, 8'hFF, 8'hFE}, '{8'h05, 8'h3C, 8'h3C}, '{8'h11, 8'h5A, 8'h00},
    '{8'h12, 8'hC3, 8'h00}, '{8'h13, 8'hFF, 8'h07}, '{8'h32, 8'h96, 8'h96},
    '{8'h33, 8'h69, 8'h69}, '{8'h00, 8'hFF, 8'h00}, '{8'h02, 8'hFF, 8'h00},
    '{8'h20, 8'hFF, 8'h00}, '{8'h34, 8'hFF, 8'h00}, '{8'hFF, 8'hFF, 8'h00}};

  always #5 mclk_in = ~mclk_in;

  // ---------------------------------------------------------------
  // Instances: default options, and open-drain melody and tone clock
  // ---------------------------------------------------------------
  derivative_register_map_ports dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .timer_two_count_in(tcount),
    .timer_expired_set_in(tset), .nvm_cycle_done_in(ndone),
    .eeprom_byte_pointer_out(ptr_o), .eeprom_data_port_out(dat_o),
    .eeprom_cycle_control_out(ctl_o), .timer_two_reload_out(rel_o),
    .eeprom_data_wr_out(dwr_o), .eeprom_data_rd_out(drd_o),
    .high_tone_frequency_out(hi_o), .low_tone_frequency_out(lo_o),
    .tone_clock_melody_control_out(tcm_o), .melody_src_in(melody_src_in),
    .melody_pin_out(mel_o), .melody_pin_oe_out(mel_oe), .aux_pins_in(aux_pins_in),
    .aux_pins_out(pins_o), .aux_pins_oe_out(pins_oe));

  derivative_register_map_ports #(
    .melody_option(deriv_regs_pkg::OPT_OPEN_DRAIN),
    .tone_clk_option(deriv_regs_pkg::OPT_OPEN_DRAIN)
  ) dut_od (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(), .timer_two_count_in(tcount),
    .timer_expired_set_in(tset), .nvm_cycle_done_in(ndone),
    .eeprom_byte_pointer_out(), .eeprom_data_port_out(), .eeprom_cycle_control_out(),
    .timer_two_reload_out(), .eeprom_data_wr_out(), .eeprom_data_rd_out(),
    .high_tone_frequency_out(), .low_tone_frequency_out(),
    .tone_clock_melody_control_out(), .melody_src_in(melody_src_in),
    .melody_pin_out(od_mel_o), .melody_pin_oe_out(od_mel_oe), .aux_pins_in(aux_pins_in),
    .aux_pins_out(od_pins_o), .aux_pins_oe_out(od_pins_oe));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd_reg

  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    q = rdata_out;
  endtask : wr_rd

  task automatic do_reset;
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    #1;
    `CHK({ctl_o, ptr_o, pins_oe, mel_oe, od_mel_oe}, 34'h0)
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  // Tone line edges over twelve cycles; push-pull must keep driving
  task automatic tone_edges(output int np, output int nod);
    logic lp, lod;
    np = 0;
    nod = 0;
    @(posedge mclk_in);
    #1;
    lp = pins_o[15];
    lod = od_pins_oe[15];
    repeat (12)
    begin
      @(posedge mclk_in);
      #1;
      if (pins_o[15] !== lp) np++;
      if (od_pins_oe[15] !== lod) nod++;
      lp = pins_o[15];
      lod = od_pins_oe[15];
      `CHK({pins_oe[15], od_pins_o[15]}, 2'b10)
    end
  endtask : tone_edges

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #20000;
    err_count++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      rd_reg(rows[i].a, rv);
      `CHK(rv, 8'h00)
      wr_rd(rows[i].a, rows[i].d, rv);
      `CHK(rv, rows[i].e)
    end
    `CHK({ptr_o, rel_o, hi_o, lo_o, tcm_o}, {8'h7F, 8'h3C, 8'h5A, 8'hC3, 3'h7})
    // Pin levels pass a two-flop synchroniser; writes to pin registers ignored
    @(posedge mclk_in) aux_pins_in <= 16'hB42D;
    wr_reg(8'h30, 8'h00);
    wr_reg(8'h31, 8'h00);
    rd_reg(8'h30, rv);
    `CHK(rv, 8'h2D)
    rd_reg(8'h31, rv);
    `CHK(rv, 8'hB4)
    @(posedge mclk_in) tcount <= 8'h77;
    wr_reg(8'h06, 8'h11);
    rd_reg(8'h06, rv);
    `CHK(rv, 8'h77)
    // Events against the control register
    wr_reg(8'h04, 8'h1E);
    @(posedge mclk_in) ndone <= 1'b1;
    @(posedge mclk_in) ndone <= 1'b0;
    rd_reg(8'h04, rv);
    `CHK(rv, 8'h00)
    @(posedge mclk_in) tset <= 1'b1;
    @(posedge mclk_in) tset <= 1'b0;
    rd_reg(8'h04, rv);
    `CHK({rv, ctl_o}, 16'h2020)
    // Same-cycle set and software clear: the set must win
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= 8'h04;
    wdata_in <= 8'h00;
    tset <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    tset <= 1'b0;
    #1;
    `CHK(ctl_o, 8'h20)
    wr_reg(8'h04, 8'h00);
    `CHK(ctl_o, 8'h00)
    // Data strobes toward the EEPROM side
    wr_reg(8'h03, 8'h3E);
    `CHK({dwr_o, dat_o}, 9'h13E)
    @(posedge mclk_in);
    #1;
    `CHK(dwr_o, 1'b0)
    rd_reg(8'h03, rv);
    `CHK({drd_o, rv}, 9'h13E)
    // Latch drives port A low where the bit is clear
    wr_reg(8'h32, 8'h0F);
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK({pins_o[7:0], pins_oe[7:0]}, 16'h00F0)
    `CHK(pins_oe[14:8], 7'h16)
    // Melody pin: push-pull versus open-drain
    wr_reg(8'h13, 8'h01);
    @(posedge mclk_in) melody_src_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK({mel_o, mel_oe, od_mel_o, od_mel_oe}, 4'b0101)
    @(posedge mclk_in) melody_src_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK({mel_o, mel_oe, od_mel_o, od_mel_oe}, 4'b1100)
    // Source low, so the idle high level can only come from the enable
    @(posedge mclk_in) melody_src_in <= 1'b0;
    wr_reg(8'h13, 8'h00);
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK({mel_o, mel_oe, od_mel_o, od_mel_oe}, 4'b1100)
    // Tone clock: divide by four, then by six
    wr_reg(8'h13, 8'h04);
    repeat (3) @(posedge mclk_in);
    tone_edges(tp, tod);
    `CHK({tp, tod}, {32'd6, 32'd6})
    wr_reg(8'h13, 8'h06);
    repeat (3) @(posedge mclk_in);
    tone_edges(tp, tod);
    `CHK({tp, tod}, {32'd4, 32'd4})
    // Second reset in mid-run clears everything written
    wr_reg(8'h33, 8'hAA);
    do_reset();
    rd_reg(8'h33, rv);
    `CHK(rv, 8'h00)
    rd_reg(8'h13, rv);
    `CHK({rv, tcm_o}, 11'h000)
    finish_test();
  end
endmodule : derivative_register_map_ports_tb_top
